//--- src/pec_top.sv
// Pin edge-change detector for ports A, B and C with an AXI4-Lite register slave
// Contract
// - Master enable set: enabled edge raises interrupt request and wake.
// - Edge during sleep is in the flag register before wake takes effect.
// - Port A rising enables occupy bits 5..0.
// - Port A falling enables occupy bits 5..0.
// - Port A flag sets on an enabled rising or falling edge.
// - Port A bits 7..6 read zero and ignore writes.
// - Port B rising enables bits 7..4; low nibble reads zero.
// - Port B falling enables bits 7..4 only.
// - Port B flag bits 7..4 set on enabled edges.
// - Port C rising enables bits 7..0.
// - Port C falling enables bits 7..0.
// - A cleared enable detects nothing of that polarity.
// - Any flag set also raises the summary flag.
// - Flags hardware-set, software read/write; writing zero clears.
// - All enables and flags reset to zero.
// - Master enable clear: flags still set, no interrupt.
// - Summary flag is OR of every flag bit.
// - Edge during a clearing write leaves the flag set.
// - Port C flag bits 7..0 set on enabled edges.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pec_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pec_pkg::pec_pins_s pins,
  input wire logic sleeping,
  output logic change_irq,
  output logic wake_req
);
  import pec_pkg::*;

  // ****************************************
  // Pin synchroniser and edge detect
  // ****************************************
  pec_pins_s sync1_r, sync2_r, prev_r;
  logic [7:0] a_now, b_now, c_now, a_old, b_old, c_old;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign a_now = {2'h0, sync2_r.a};
  assign a_old = {2'h0, prev_r.a};
  assign b_now = {sync2_r.b, 4'h0};
  assign b_old = {prev_r.b, 4'h0};
  assign c_now = sync2_r.c;
  assign c_old = prev_r.c;

  function automatic logic [7:0] edge_hits(input logic [7:0] now, input logic [7:0] old,
                                           input logic [7:0] rise, input logic [7:0] fall,
                                           input logic [7:0] mask);
    // Enable of zero blocks that polarity entirely
    edge_hits = ((now & ~old & rise) | (~now & old & fall)) & mask;
  endfunction

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  logic aw_held_r, w_held_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;

  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  logic wr_hit_ok;
  logic [7:0] wbyte;
  logic wlane;
  assign wbyte = wdata_r[7:0];
  assign wlane = wstrb_r[0];

  always_comb begin
    unique case (waddr_r)
      PEC_OFF_A_RISE, PEC_OFF_A_FALL, PEC_OFF_A_FLAG, PEC_OFF_B_RISE, PEC_OFF_B_FALL,
      PEC_OFF_B_FLAG, PEC_OFF_C_RISE, PEC_OFF_C_FALL, PEC_OFF_C_FLAG, PEC_OFF_CTRL: begin
        wr_hit_ok = 1'b1;
      end
      default: begin
        wr_hit_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PEC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit_ok ? PEC_RESP_OKAY : PEC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Enable registers
  // ****************************************
  pec_port_s pa_r, pb_r, pc_r;
  logic master_en_r;

  function automatic logic [7:0] wr_field(input logic [7:0] cur, input logic hit,
                                          input logic [7:0] mask);
    wr_field = (hit && wlane) ? (wbyte & mask) : cur;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_r.rise <= PEC_RST_BYTE;
      pa_r.fall <= PEC_RST_BYTE;
      pb_r.rise <= PEC_RST_BYTE;
      pb_r.fall <= PEC_RST_BYTE;
      pc_r.rise <= PEC_RST_BYTE;
      pc_r.fall <= PEC_RST_BYTE;
      master_en_r <= 1'b0;
    end else if (wr_go) begin
      pa_r.rise <= wr_field(pa_r.rise, waddr_r == PEC_OFF_A_RISE, PEC_MASK_A);
      pa_r.fall <= wr_field(pa_r.fall, waddr_r == PEC_OFF_A_FALL, PEC_MASK_A);
      pb_r.rise <= wr_field(pb_r.rise, waddr_r == PEC_OFF_B_RISE, PEC_MASK_B);
      pb_r.fall <= wr_field(pb_r.fall, waddr_r == PEC_OFF_B_FALL, PEC_MASK_B);
      pc_r.rise <= wr_field(pc_r.rise, waddr_r == PEC_OFF_C_RISE, PEC_MASK_C);
      pc_r.fall <= wr_field(pc_r.fall, waddr_r == PEC_OFF_C_FALL, PEC_MASK_C);
      if (waddr_r == PEC_OFF_CTRL && wlane) begin
        master_en_r <= wbyte[PEC_CTRL_EN_BIT];
      end
    end
  end

  // ****************************************
  // Flags: hardware set beats software clear
  // ****************************************
  logic [7:0] hit_a, hit_b, hit_c;
  assign hit_a = edge_hits(a_now, a_old, pa_r.rise, pa_r.fall, PEC_MASK_A);
  assign hit_b = edge_hits(b_now, b_old, pb_r.rise, pb_r.fall, PEC_MASK_B);
  assign hit_c = edge_hits(c_now, c_old, pc_r.rise, pc_r.fall, PEC_MASK_C);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_r.flag <= PEC_RST_BYTE;
      pb_r.flag <= PEC_RST_BYTE;
      pc_r.flag <= PEC_RST_BYTE;
    end else begin
      // Written value applied first, then new edges ORed on top
      pa_r.flag <= (wr_go ? wr_field(pa_r.flag, waddr_r == PEC_OFF_A_FLAG, PEC_MASK_A)
                          : pa_r.flag) | hit_a;
      pb_r.flag <= (wr_go ? wr_field(pb_r.flag, waddr_r == PEC_OFF_B_FLAG, PEC_MASK_B)
                          : pb_r.flag) | hit_b;
      pc_r.flag <= (wr_go ? wr_field(pc_r.flag, waddr_r == PEC_OFF_C_FLAG, PEC_MASK_C)
                          : pc_r.flag) | hit_c;
    end
  end

  // ****************************************
  // Summary, interrupt and wake
  // ****************************************
  logic summary;
  assign summary = |{pa_r.flag, pb_r.flag, pc_r.flag};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      change_irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      // Gating only; detection runs regardless of the master enable
      change_irq <= master_en_r && summary;
      // Wake follows the flag, so the flag is already visible at wake
      wake_req <= master_en_r && summary && sleeping;
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  logic [7:0] rd_byte;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      PEC_OFF_A_RISE: rd_byte = pa_r.rise;
      PEC_OFF_A_FALL: rd_byte = pa_r.fall;
      PEC_OFF_A_FLAG: rd_byte = pa_r.flag;
      PEC_OFF_B_RISE: rd_byte = pb_r.rise;
      PEC_OFF_B_FALL: rd_byte = pb_r.fall;
      PEC_OFF_B_FLAG: rd_byte = pb_r.flag;
      PEC_OFF_C_RISE: rd_byte = pc_r.rise;
      PEC_OFF_C_FALL: rd_byte = pc_r.fall;
      PEC_OFF_C_FLAG: rd_byte = pc_r.flag;
      PEC_OFF_CTRL: rd_byte = {5'h00, sleeping, summary, master_en_r};
      default: begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PEC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_ok ? PEC_RESP_OKAY : PEC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_IRQ_ON: assert property (@(posedge aclk) disable iff (!aresetn)
    (master_en_r && summary) |=> change_irq) else $error("irq missing");
  AST_IRQ_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    !master_en_r |=> !change_irq) else $error("irq while disabled");
  AST_A_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    (sync2_r.a[0] && !prev_r.a[0] && pa_r.rise[0]) |=> pa_r.flag[0]) else $error("A flag");
  AST_A_TOP: assert property (@(posedge aclk) disable iff (!aresetn)
    pa_r.rise[7:6] == 2'h0 && pa_r.flag[7:6] == 2'h0) else $error("A top bits");
  AST_B_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    pb_r.rise[3:0] == 4'h0 && pb_r.flag[3:0] == 4'h0) else $error("B low bits");
  AST_C_FALL: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sync2_r.c[7] && prev_r.c[7] && pc_r.fall[7]) |=> pc_r.flag[7]) else $error("C flag");
  AST_NO_EN: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pc_r.flag[0] && !pc_r.rise[0] && !pc_r.fall[0] && !wr_go) |=> !pc_r.flag[0])
    else $error("flag without enable");
  AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && hit_b[4]) |=> pb_r.flag[4]) else $error("edge lost on clear");
  AST_SUM: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit_a != 8'h00) |=> summary) else $error("summary missing");
  AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_req |-> $past(summary)) else $error("wake before flag");
  AST_RESET: assert property (@(posedge aclk)
    !aresetn |=> (pa_r == '0 && pb_r == '0 && pc_r == '0)) else $error("reset values");

endmodule

`default_nettype wire

//--- shared/pec_pkg.sv
// Package: register map, field layout and bus types for the pin change detector
package pec_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] PEC_OFF_A_RISE = 8'h00;
  localparam logic [7:0] PEC_OFF_A_FALL = 8'h04;
  localparam logic [7:0] PEC_OFF_A_FLAG = 8'h08;
  localparam logic [7:0] PEC_OFF_B_RISE = 8'h0C;
  localparam logic [7:0] PEC_OFF_B_FALL = 8'h10;
  localparam logic [7:0] PEC_OFF_B_FLAG = 8'h14;
  localparam logic [7:0] PEC_OFF_C_RISE = 8'h18;
  localparam logic [7:0] PEC_OFF_C_FALL = 8'h1C;
  localparam logic [7:0] PEC_OFF_C_FLAG = 8'h20;
  localparam logic [7:0] PEC_OFF_CTRL = 8'h24;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam logic [7:0] PEC_MASK_A = 8'h3F;
  localparam logic [7:0] PEC_MASK_B = 8'hF0;
  localparam logic [7:0] PEC_MASK_C = 8'hFF;
  localparam logic [7:0] PEC_RST_BYTE = 8'h00;
  localparam int PEC_CTRL_EN_BIT = 0;
  localparam int PEC_CTRL_SUM_BIT = 1;
  localparam int PEC_CTRL_SLEEP_BIT = 2;
  localparam logic [1:0] PEC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PEC_RESP_SLVERR = 2'h2;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [5:0] a;
    logic [7:4] b;
    logic [7:0] c;
  } pec_pins_s;

  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] flag;
  } pec_port_s;

endpackage

//--- sim/pec_pin_model.sv
// Partner model: external drivers on the port A, B and C pins
`timescale 1ns/1ps
`default_nettype none

module pec_pin_model
  import pec_pkg::*;
(
  input wire logic aclk,
  input wire pec_pkg::pec_pins_s target,
  input wire logic slow,
  output var pec_pkg::pec_pins_s pins
);
  pec_pins_s lag_r;

  initial begin
    lag_r = '0;
    pins = '0;
  end

  // Slow mode lags one more cycle, like a weak driver on a loaded line
  always @(posedge aclk) begin
    lag_r <= target;
    pins <= slow ? lag_r : target;
  end
endmodule

`default_nettype wire

//--- sim/tb_top.sv
// Testbench for the pin edge-change detector
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pec_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic sleeping = 0, slow = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, change_irq, wake_req;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  pec_pins_s target = '0;
  pec_pins_s pins;
  int fail_count = 0, num_checks = 0, cyc = 0;
  localparam logic [7:0] OFF[10] = '{PEC_OFF_A_RISE, PEC_OFF_A_FALL, PEC_OFF_A_FLAG,
    PEC_OFF_B_RISE, PEC_OFF_B_FALL, PEC_OFF_B_FLAG, PEC_OFF_C_RISE, PEC_OFF_C_FALL,
    PEC_OFF_C_FLAG, PEC_OFF_CTRL};
  localparam logic [7:0] MSK[3] = '{PEC_MASK_A, PEC_MASK_B, PEC_MASK_C};

  pec_top u_pec_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins),
    .sleeping(sleeping), .change_irq(change_irq), .wake_req(wake_req));

  pec_pin_model u_pec_pin_model (.aclk(aclk), .target(target), .slow(slow), .pins(pins));

  always #5 aclk = ~aclk;

  // ****
  // Reporting and comparisons
  // ****
  task final_report;
    $display("Comparisons %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang must still end in the verdict
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // ****
  // AXI4-Lite master
  // ****
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw = 0;
    bit w = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_word({30'h0, r}, {30'h0, PEC_RESP_OKAY}, "write resp");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [1:0] r;
    logic [31:0] d;
    axi_rd(a, d, r);
    chk_word(d, {24'h000000, exp}, "read data");
    chk_word({30'h0, r}, {30'h0, PEC_RESP_OKAY}, "read resp");
  endtask

  // ****
  // Helpers
  // ****
  task automatic set_en(input logic [7:0] rise, input logic [7:0] fall);
    for (int p = 0; p < 3; p++) begin
      wr_ok(OFF[3*p], rise);
      wr_ok(OFF[3*p+1], fall);
    end
  endtask

  // Mask only the bits seen set, so an edge landing meanwhile survives
  task automatic clr_flags;
    logic [1:0] r;
    logic [31:0] v;
    logic [7:0] m;
    for (int p = 0; p < 3; p++) begin
      axi_rd(OFF[3*p+2], v, r);
      m = v[7:0] ^ 8'hFF;
      // Fresh value ANDed with the mask, so only the bits seen set are dropped
      axi_rd(OFF[3*p+2], v, r);
      wr_ok(OFF[3*p+2], v[7:0] & m);
    end
  endtask

  task automatic chk_flags(input bit on);
    for (int p = 0; p < 3; p++) rd_chk(OFF[3*p+2], on ? MSK[p] : 8'h00);
  endtask

  task automatic drive(input bit hi);
    target <= hi ? '1 : '0;
    repeat (8) @(posedge aclk);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    logic [1:0] r;
    logic [31:0] d;
    for (int i = 0; i < 10; i++) rd_chk(OFF[i], PEC_RST_BYTE);
    axi_rd(8'h28, d, r);
    chk_word(d, 32'h0, "unmapped read data");
    chk_word({30'h0, r}, {30'h0, PEC_RESP_SLVERR}, "unmapped read resp");
    axi_wr(8'h28, 8'hFF, r);
    chk_word({30'h0, r}, {30'h0, PEC_RESP_SLVERR}, "unmapped write resp");
    $display("t_reset done");
  endtask

  task automatic t_masks;
    for (int i = 0; i < 9; i++) begin
      wr_ok(OFF[i], 8'hFF);
      rd_chk(OFF[i], MSK[i/3]);
    end
    rd_chk(PEC_OFF_CTRL, 8'h02);
    chk_bit(change_irq, 1'b0, "irq with master off");
    for (int i = 0; i < 9; i++) wr_ok(OFF[i], 8'h00);
    rd_chk(PEC_OFF_CTRL, 8'h00);
    $display("t_masks done");
  endtask

  task automatic t_rise;
    set_en(8'hFF, 8'h00);
    drive(1);
    chk_flags(1);
    rd_chk(PEC_OFF_CTRL, 8'h02);
    chk_bit(change_irq, 1'b0, "irq with master off");
    clr_flags();
    drive(0);
    chk_flags(0);
    $display("t_rise done");
  endtask

  task automatic t_fall;
    set_en(8'h00, 8'hFF);
    drive(1);
    chk_flags(0);
    drive(0);
    chk_flags(1);
    clr_flags();
    rd_chk(PEC_OFF_CTRL, 8'h00);
    $display("t_fall done");
  endtask

  task automatic t_wake;
    slow <= 1;
    sleeping <= 1;
    wr_ok(PEC_OFF_CTRL, 8'h01);
    drive(1);
    chk_bit(wake_req, 1'b0, "wake on disabled edge");
    drive(0);
    chk_bit(change_irq, 1'b1, "irq");
    chk_bit(wake_req, 1'b1, "wake");
    chk_flags(1);
    rd_chk(PEC_OFF_CTRL, 8'h07);
    clr_flags();
    rd_chk(PEC_OFF_CTRL, 8'h05);
    chk_bit(change_irq, 1'b0, "irq after clear");
    sleeping <= 0;
    $display("t_wake done");
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_masks();
    t_rise();
    t_fall();
    t_wake();
    final_report();
  end
endmodule

`default_nettype wire
